// File: src/liu_status_interrupt_regs.sv
`timescale 1ns/100ps
// Functional notes
// (RULE_01) Power bit 4 turns receiver on/off
// (RULE_02) Power bit 0 enables transmitter, else tristate
// (RULE_03) Driver fail enable gates its interrupt
// (RULE_04) Signal loss enable gates its interrupt
// (RULE_05) Lock loss enable gates its interrupt
// (RULE_06) FIFO limit enable, ignored when attenuator off
// (RULE_07) Pattern error enable gates its interrupt
// (RULE_08) Counter full enable interrupts at 0xFFFF
// (RULE_09) Status changes set flags D0-D3, read clears
// (RULE_10) Pattern error sets flag D4, read clears
// (RULE_11) Counter saturation sets flag D5, read clears
// (RULE_12) Driver alarm after 128 quiet bit periods
// (RULE_13) Live signal loss alarms at D1, D4, D5
// (RULE_14) Live lock loss alarm at D2
// (RULE_15) Live FIFO limit alarm at D3
// (RULE_16) Live pattern error at D6
// (RULE_17) Part and revision bytes at 0x3E, 0x3F
// (RULE_18) Active low interrupt output to host
// (RULE_19) Reading FIFO alarm resets FIFO, clears bit
// (RULE_20) Interrupt needs global enable; pending bit reports
// (RULE_21) 16-bit saturating error counter, two bytes
module liu_status_interrupt_regs
  import liu_regs_pkg::*;
#(
  parameter int         BIT_DIV = 1,
  parameter logic [7:0] PART_ID = 8'h5a, // Arbitrary value
  parameter logic [7:0] REV_ID  = 8'h01  // Arbitrary value
) (
  input  wire logic  I_REF_CLK,
  input  wire logic  I_RSTN,
  input  wire logic  I_SCLK,
  input  wire logic  I_SDI,
  input  wire logic  I_CS_N,
  output logic       O_SDO,
  output logic       O_SDO_OE,
  output logic       O_INT_N,
  input  wire logic  I_MONITOR_IN_POSITIVE,
  input  wire logic  I_MONITOR_IN_NEGATIVE,
  input  wire logic  I_TX_POS_DATA,
  input  wire logic  I_TX_NEG_DATA,
  output logic       O_LINE_TX_POSITIVE,
  output logic       O_LINE_TX_POSITIVE_OE,
  output logic       O_LINE_TX_NEGATIVE,
  output logic       O_LINE_TX_NEGATIVE_OE,
  output logic       O_RECEIVER_POWER,
  input  wire logic  I_RECEIVE_SIGNAL_LOSS,
  input  wire logic  I_RECEIVE_LOCK_LOSS,
  input  wire logic  I_ANALOG_SIGNAL_LOSS,
  input  wire logic  I_DIGITAL_SIGNAL_LOSS,
  input  wire logic  I_FIFO_LIMIT,
  input  wire logic  I_JA_ENABLED,
  input  wire logic  I_PATTERN_ERROR,
  output logic       O_FIFO_RESET
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic                      bus_rd;
  logic                      bus_wr;
  logic [ADDR_W-1:0]         bus_addr;
  logic [7:0]                bus_wdata;
  logic [7:0]                bus_rdata;
  logic                      driver_monitor_alarm;
  logic                      fifo_limit_alarm;
  logic                      fl_mask_q;
  logic [7:0]                power_q;
  logic [7:0]                irq_en_q;
  logic [7:0]                girq_q;
  logic [NUM_SRC-1:0]        flags_q;
  logic [NUM_SRC-1:0]        flag_set;
  logic [NUM_SRC-1:0]        en_eff;
  logic [NUM_LEVEL_SRC-1:0]  level_now;
  logic [NUM_LEVEL_SRC-1:0]  level_prev_q;
  logic [ERR_W-1:0]          err_cnt_q;
  logic [7:0]                hold_q;
  logic                      sat_event;
  logic                      err_clear;
  logic                      global_irq_pending;
  logic [7:0]                alarm_byte;

  // Access to one register address
  function automatic logic hit(input logic strobe, input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] target);
    hit = strobe & (a == target);
  endfunction

  // ----------------------------------------------------------------
  // Serial host port and driver monitor
  // ----------------------------------------------------------------
  host_serial_port u_port (
    .i_clk    (I_REF_CLK),
    .i_rstn   (I_RSTN),
    .i_sclk   (I_SCLK),
    .i_sdi    (I_SDI),
    .i_cs_n   (I_CS_N),
    .i_rdata  (bus_rdata),
    .o_sdo    (O_SDO),
    .o_sdo_oe (O_SDO_OE),
    .o_rd     (bus_rd),
    .o_wr     (bus_wr),
    .o_addr   (bus_addr),
    .o_wdata  (bus_wdata)
  );

  driver_monitor #(
    .BIT_DIV (BIT_DIV)
  ) u_dmon (
    .i_clk     (I_REF_CLK),
    .i_rstn    (I_RSTN),
    .i_mon_pos (I_MONITOR_IN_POSITIVE),
    .i_mon_neg (I_MONITOR_IN_NEGATIVE),
    .o_alarm   (driver_monitor_alarm)
  );

  // ----------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      power_q  <= REG_RESET;
      irq_en_q <= REG_RESET;
      girq_q   <= REG_RESET;
    end else begin
      if (hit(bus_wr, bus_addr, ADDR_POWER)) begin
        power_q <= bus_wdata & POWER_MASK; // RULE_01 RULE_02
      end
      if (hit(bus_wr, bus_addr, ADDR_IRQ_EN)) begin
        irq_en_q <= bus_wdata & IRQ_EN_MASK;
      end
      if (hit(bus_wr, bus_addr, ADDR_GIRQ_CTRL)) begin
        girq_q <= bus_wdata & GIRQ_MASK;
      end
    end
  end

  assign O_RECEIVER_POWER = power_q[BIT_RX_POWER]; // RULE_01

  // ----------------------------------------------------------------
  // Transmit line drivers, tristated when off
  // ----------------------------------------------------------------
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_LINE_TX_POSITIVE <= 1'b0;
      O_LINE_TX_NEGATIVE <= 1'b0;
    end else begin
      O_LINE_TX_POSITIVE <= I_TX_POS_DATA & power_q[BIT_TX_POWER];
      O_LINE_TX_NEGATIVE <= I_TX_NEG_DATA & power_q[BIT_TX_POWER];
    end
  end

  assign O_LINE_TX_POSITIVE_OE = power_q[BIT_TX_POWER]; // RULE_02
  assign O_LINE_TX_NEGATIVE_OE = power_q[BIT_TX_POWER]; // RULE_02

  // ----------------------------------------------------------------
  // FIFO limit alarm and reset on read
  // ----------------------------------------------------------------
  assign fifo_limit_alarm = I_FIFO_LIMIT & ~fl_mask_q; // RULE_15

  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      fl_mask_q    <= 1'b0;
      O_FIFO_RESET <= 1'b0;
    end else begin
      O_FIFO_RESET <= hit(bus_rd, bus_addr, ADDR_ALARM) & fifo_limit_alarm; // RULE_19
      if (hit(bus_rd, bus_addr, ADDR_ALARM) && fifo_limit_alarm) begin
        fl_mask_q <= 1'b1; // RULE_19
      end else if (!I_FIFO_LIMIT) begin
        fl_mask_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pattern error counter and holding byte
  // ----------------------------------------------------------------
  assign err_clear = hit(bus_rd, bus_addr, ADDR_ERR_HIGH);
  assign sat_event = I_PATTERN_ERROR & (err_cnt_q == ERR_NEAR_MAX) & ~err_clear;

  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      err_cnt_q <= '0;
      hold_q    <= REG_RESET;
    end else begin
      if (err_clear) begin
        hold_q    <= err_cnt_q[7:0];
        err_cnt_q <= {{(ERR_W-1){1'b0}}, I_PATTERN_ERROR};
      end else if (I_PATTERN_ERROR && err_cnt_q != ERR_MAX) begin
        err_cnt_q <= err_cnt_q + 16'h0001; // RULE_21
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt flags, set wins over clear on read
  // ----------------------------------------------------------------
  assign level_now = {fifo_limit_alarm, I_RECEIVE_LOCK_LOSS,
                      I_RECEIVE_SIGNAL_LOSS, driver_monitor_alarm};

  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      level_prev_q <= '0;
    end else begin
      level_prev_q <= level_now;
    end
  end

  assign flag_set[NUM_LEVEL_SRC-1:0] = level_now ^ level_prev_q; // RULE_09
  assign flag_set[SRC_PATTERN]       = I_PATTERN_ERROR;            // RULE_10
  assign flag_set[SRC_COUNTER]       = sat_event;                  // RULE_11

  generate
    for (genvar g = 0; g < NUM_SRC; g++) begin : g_flag
      always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
          flags_q[g] <= 1'b0;
        end else if (flag_set[g]) begin
          flags_q[g] <= 1'b1; // RULE_09
        end else if (hit(bus_rd, bus_addr, ADDR_IRQ_FLAGS)) begin
          flags_q[g] <= 1'b0; // RULE_09 RULE_10 RULE_11
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Interrupt gating and output pin
  // ----------------------------------------------------------------
  always_comb begin
    en_eff           = irq_en_q[NUM_SRC-1:0]; // RULE_03 RULE_04 RULE_05 RULE_07 RULE_08
    en_eff[SRC_FIFO] = irq_en_q[SRC_FIFO] & I_JA_ENABLED; // RULE_06
  end

  assign global_irq_pending = girq_q[BIT_GIRQ] & |(flags_q & en_eff); // RULE_20

  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_INT_N <= 1'b1;
    end else begin
      O_INT_N <= ~global_irq_pending; // RULE_18
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  assign alarm_byte = {1'b0, I_PATTERN_ERROR, I_DIGITAL_SIGNAL_LOSS, // RULE_16 RULE_13
                       I_ANALOG_SIGNAL_LOSS, fifo_limit_alarm,       // RULE_13 RULE_15
                       I_RECEIVE_LOCK_LOSS, I_RECEIVE_SIGNAL_LOSS,   // RULE_14 RULE_13
                       driver_monitor_alarm};                        // RULE_12

  always_comb begin
    case (bus_addr)
      ADDR_POWER:      bus_rdata = power_q;
      ADDR_IRQ_EN:     bus_rdata = irq_en_q;
      ADDR_IRQ_FLAGS:  bus_rdata = {2'b00, flags_q};
      ADDR_ALARM:      bus_rdata = alarm_byte;
      ADDR_GIRQ_CTRL:  bus_rdata = girq_q;
      ADDR_GIRQ_STATE: bus_rdata = {7'h00, global_irq_pending}; // RULE_20
      ADDR_ERR_HIGH:   bus_rdata = err_cnt_q[15:8]; // RULE_21
      ADDR_ERR_LOW:    bus_rdata = err_cnt_q[7:0];  // RULE_21
      ADDR_HOLD:       bus_rdata = hold_q;
      ADDR_PART_ID:    bus_rdata = PART_ID; // RULE_17
      ADDR_REV_ID:     bus_rdata = REV_ID;  // RULE_17
      default:         bus_rdata = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RSTN);

  property p_rx_power;
    hit(bus_wr, bus_addr, ADDR_POWER) |=> O_RECEIVER_POWER == $past(bus_wdata[BIT_RX_POWER]);
  endproperty
  a_rx_power: assert property (p_rx_power) // RULE_01
    else $error("receiver power does not follow written bit");

  property p_tx_off;
    hit(bus_wr, bus_addr, ADDR_POWER) && !bus_wdata[BIT_TX_POWER]
      |=> !O_LINE_TX_POSITIVE_OE && !O_LINE_TX_NEGATIVE_OE ##1 !O_LINE_TX_POSITIVE;
  endproperty
  a_tx_off: assert property (p_tx_off) // RULE_02
    else $error("transmitter still driving after turn off");

  property p_driver_irq;
    girq_q[BIT_GIRQ] && irq_en_q[SRC_DRIVER] && flags_q[SRC_DRIVER] |=> !O_INT_N;
  endproperty
  a_driver_irq: assert property (p_driver_irq) // RULE_03
    else $error("enabled driver flag did not raise interrupt");

  property p_masked_idle;
    (flags_q & en_eff) == '0 |=> O_INT_N;
  endproperty
  a_masked_idle: assert property (p_masked_idle) // RULE_04
    else $error("interrupt raised with no enabled flag");

  property p_fifo_ignored;
    !I_JA_ENABLED && (flags_q & irq_en_q[NUM_SRC-1:0]) == (1 << SRC_FIFO) |=> O_INT_N;
  endproperty
  a_fifo_ignored: assert property (p_fifo_ignored) // RULE_06
    else $error("fifo interrupt with attenuator off");

  property p_los_change;
    $changed(I_RECEIVE_SIGNAL_LOSS) |=> flags_q[SRC_RX_LOS];
  endproperty
  a_los_change: assert property (p_los_change) // RULE_09
    else $error("signal loss change not flagged");

  property p_pattern_flag;
    I_PATTERN_ERROR |=> flags_q[SRC_PATTERN] && err_cnt_q != '0;
  endproperty
  a_pattern_flag: assert property (p_pattern_flag) // RULE_10
    else $error("pattern error not flagged");

  property p_sat_flag;
    sat_event |=> flags_q[SRC_COUNTER] && err_cnt_q == ERR_MAX;
  endproperty
  a_sat_flag: assert property (p_sat_flag) // RULE_11
    else $error("saturation not flagged");

  property p_fifo_reset;
    hit(bus_rd, bus_addr, ADDR_ALARM) && fifo_limit_alarm |=> O_FIFO_RESET ##1 !O_FIFO_RESET;
  endproperty
  a_fifo_reset: assert property (p_fifo_reset) // RULE_19
    else $error("fifo reset pulse missing");

  property p_global_off;
    !girq_q[BIT_GIRQ] |=> O_INT_N;
  endproperty
  a_global_off: assert property (p_global_off) // RULE_20
    else $error("interrupt raised with global enable off");

  property p_counter_hold;
    err_cnt_q == ERR_MAX && !err_clear |=> err_cnt_q == ERR_MAX;
  endproperty
  a_counter_hold: assert property (p_counter_hold) // RULE_21
    else $error("error counter wrapped");

  property p_cov_sat;
    sat_event;
  endproperty
  c_cov_sat: cover property (p_cov_sat);

  property p_cov_int;
    $fell(O_INT_N);
  endproperty
  c_cov_int: cover property (p_cov_int);

  property p_cov_flag_read;
    hit(bus_rd, bus_addr, ADDR_IRQ_FLAGS) && flags_q != '0;
  endproperty
  c_cov_flag_read: cover property (p_cov_flag_read);

endmodule // liu_status_interrupt_regs

// File: pkg/liu_regs_pkg.sv
package liu_regs_pkg;

  // ------------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------------
  localparam int          ADDR_W          = 6;
  localparam logic [5:0]  ADDR_POWER      = 6'h00;
  localparam logic [5:0]  ADDR_IRQ_EN     = 6'h01;
  localparam logic [5:0]  ADDR_IRQ_FLAGS  = 6'h02;
  localparam logic [5:0]  ADDR_ALARM      = 6'h03;
  localparam logic [5:0]  ADDR_GIRQ_CTRL  = 6'h20;
  localparam logic [5:0]  ADDR_GIRQ_STATE = 6'h21;
  localparam logic [5:0]  ADDR_ERR_HIGH   = 6'h30;
  localparam logic [5:0]  ADDR_ERR_LOW    = 6'h31;
  localparam logic [5:0]  ADDR_HOLD       = 6'h38;
  localparam logic [5:0]  ADDR_PART_ID    = 6'h3e;
  localparam logic [5:0]  ADDR_REV_ID     = 6'h3f;

  // ------------------------------------------------------------------
  // Field layout and reset values
  // ------------------------------------------------------------------
  localparam logic [7:0]  REG_RESET       = 8'h00;
  localparam logic [7:0]  POWER_MASK      = 8'h11;
  localparam logic [7:0]  IRQ_EN_MASK     = 8'h3f;
  localparam logic [7:0]  GIRQ_MASK       = 8'h01;
  localparam int          BIT_TX_POWER    = 0;
  localparam int          BIT_RX_POWER    = 4;
  localparam int          BIT_GIRQ        = 0;
  localparam int          SRC_DRIVER      = 0;
  localparam int          SRC_RX_LOS      = 1;
  localparam int          SRC_RX_LOL      = 2;
  localparam int          SRC_FIFO        = 3;
  localparam int          SRC_PATTERN     = 4;
  localparam int          SRC_COUNTER     = 5;
  localparam int          NUM_SRC         = 6;
  localparam int          NUM_LEVEL_SRC   = 4;

  // ------------------------------------------------------------------
  // Counter and timing constants
  // ------------------------------------------------------------------
  localparam int          ERR_W           = 16;
  localparam logic [15:0] ERR_MAX         = 16'hffff;
  localparam logic [15:0] ERR_NEAR_MAX    = 16'hfffe;
  localparam int          DM_QUIET_BITS   = 128;
  localparam logic [7:0]  DM_QUIET_LAST   = 8'h7f;

  // ------------------------------------------------------------------
  // Serial frame layout: rw, six address bits, one spare, eight data
  // ------------------------------------------------------------------
  localparam logic [2:0]  FRAME_BYTE_LAST = 3'h7;
  localparam int          HDR_RW          = 0;
  localparam int          HDR_ADDR_LSB    = 1;

  typedef enum logic [1:0] {PH_HEADER, PH_DATA, PH_DONE} phase_t;

endpackage

// File: src/host_serial_port.sv
`timescale 1ns/100ps
module host_serial_port
  import liu_regs_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_rstn,
  input  wire logic              i_sclk,
  input  wire logic              i_sdi,
  input  wire logic              i_cs_n,
  input  wire logic [7:0]        i_rdata,
  output logic                   o_sdo,
  output logic                   o_sdo_oe,
  output logic                   o_rd,
  output logic                   o_wr,
  output logic [ADDR_W-1:0]      o_addr,
  output logic [7:0]             o_wdata
);

  logic [2:0]  sclk_sync_q;
  logic [1:0]  sdi_sync_q;
  logic [1:0]  csn_sync_q;
  logic        rise;
  logic        fall;
  logic        cs_active;
  logic [7:0]  in_sr_q;
  logic [7:0]  byte_now;
  logic [7:0]  out_sr_q;
  logic [2:0]  bit_cnt_q;
  logic        rw_q;
  phase_t      phase_q;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sclk_sync_q <= 3'h0;
      sdi_sync_q  <= 2'h0;
      csn_sync_q  <= 2'h3;
    end else begin
      sclk_sync_q <= {sclk_sync_q[1:0], i_sclk};
      sdi_sync_q  <= {sdi_sync_q[0], i_sdi};
      csn_sync_q  <= {csn_sync_q[0], i_cs_n};
    end
  end

  // Edge detection on the second and third stages only
  assign rise      = sclk_sync_q[1] & ~sclk_sync_q[2];
  assign fall      = ~sclk_sync_q[1] & sclk_sync_q[2];
  assign cs_active = ~csn_sync_q[1];
  assign byte_now  = {sdi_sync_q[1], in_sr_q[7:1]};

  // ----------------------------------------------------------------
  // Frame sequencing, LSB first on rising clock
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      phase_q   <= PH_HEADER;
      bit_cnt_q <= 3'h0;
      in_sr_q   <= 8'h00;
      rw_q      <= 1'b0;
      o_addr    <= '0;
      o_wdata   <= 8'h00;
    end else if (!cs_active) begin
      phase_q   <= PH_HEADER;
      bit_cnt_q <= 3'h0;
      rw_q      <= 1'b0;
    end else if (rise) begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      in_sr_q   <= byte_now;
      unique case (phase_q)
        PH_HEADER: if (bit_cnt_q == FRAME_BYTE_LAST) begin
          rw_q    <= byte_now[HDR_RW];
          o_addr  <= byte_now[HDR_ADDR_LSB +: ADDR_W];
          phase_q <= PH_DATA;
        end
        PH_DATA: if (bit_cnt_q == FRAME_BYTE_LAST) begin
          o_wdata <= byte_now;
          phase_q <= PH_DONE;
        end
        PH_DONE: phase_q <= PH_DONE;
      endcase
    end
  end

  // Access strobes, one cycle each
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rd <= 1'b0;
      o_wr <= 1'b0;
    end else begin
      o_rd <= cs_active & rise & (phase_q == PH_HEADER)
              & (bit_cnt_q == FRAME_BYTE_LAST) & byte_now[HDR_RW];
      o_wr <= cs_active & rise & (phase_q == PH_DATA)
              & (bit_cnt_q == FRAME_BYTE_LAST) & ~rw_q;
    end
  end

  // ----------------------------------------------------------------
  // Read data out, changed on falling clock
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      out_sr_q <= 8'h00;
      o_sdo    <= 1'b0;
    end else if (o_rd) begin
      out_sr_q <= i_rdata;
    end else if (fall && rw_q && phase_q == PH_DATA) begin
      o_sdo    <= out_sr_q[0];
      out_sr_q <= {1'b0, out_sr_q[7:1]};
    end
  end

  assign o_sdo_oe = cs_active & rw_q & (phase_q == PH_DATA);

  property p_single_strobe;
    @(posedge i_clk) disable iff (!i_rstn)
    (o_rd || o_wr) |=> !(o_rd || o_wr);
  endproperty
  a_single_strobe: assert property (p_single_strobe)
    else $error("serial strobe longer than one cycle");

endmodule // host_serial_port

// File: src/driver_monitor.sv
`timescale 1ns/100ps
module driver_monitor
  import liu_regs_pkg::*;
#(
  parameter int BIT_DIV = 1
) (
  input  wire logic  i_clk,
  input  wire logic  i_rstn,
  input  wire logic  i_mon_pos,
  input  wire logic  i_mon_neg,
  output logic       o_alarm
);

  logic [1:0]  pos_sync_q;
  logic [1:0]  neg_sync_q;
  logic        pulse_now;
  logic        pulse_seen_q;
  logic        bit_en;
  logic [15:0] div_q;
  logic [7:0]  quiet_cnt_q;

  // Monitor pin synchronisers
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pos_sync_q <= 2'h0;
      neg_sync_q <= 2'h0;
    end else begin
      pos_sync_q <= {pos_sync_q[0], i_mon_pos};
      neg_sync_q <= {neg_sync_q[0], i_mon_neg};
    end
  end

  assign pulse_now = pos_sync_q[1] | neg_sync_q[1];

  // Bit period enable
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      div_q <= 16'h0000;
    end else if (bit_en) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end

  assign bit_en = (div_q == 16'(BIT_DIV - 1));

  // Pulse memory for the current bit period
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pulse_seen_q <= 1'b0;
    end else begin
      pulse_seen_q <= pulse_now | (pulse_seen_q & ~bit_en);
    end
  end

  // Quiet bit count and alarm
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      quiet_cnt_q <= 8'h00;
      o_alarm     <= 1'b0;
    end else if (bit_en) begin
      if (pulse_seen_q || pulse_now) begin
        quiet_cnt_q <= 8'h00;
        o_alarm     <= 1'b0;
      end else if (quiet_cnt_q == DM_QUIET_LAST) begin
        o_alarm     <= 1'b1; // RULE_12
      end else begin
        quiet_cnt_q <= quiet_cnt_q + 8'h01;
      end
    end
  end

  property p_quiet_alarm;
    @(posedge i_clk) disable iff (!i_rstn)
    $rose(o_alarm) |-> $past(quiet_cnt_q) == DM_QUIET_LAST && !$past(pulse_seen_q);
  endproperty
  a_quiet_alarm: assert property (p_quiet_alarm) // RULE_12
    else $error("driver alarm raised without 128 quiet bits");

endmodule // driver_monitor

// File: verification/liu_host_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// Serial host processor
// ----------------------------------------
module liu_host_model (
  input  wire logic i_clk,
  input  wire logic i_sdo,
  output logic      o_sclk,
  output logic      o_sdi,
  output logic      o_cs_n
);
  // Idle bus levels
  initial begin
    o_sclk = 1'b0;
    o_sdi  = 1'b0;
    o_cs_n = 1'b1;
  end
  // One framed access, eight ref clocks per serial clock level
  task automatic xfer(input logic [15:0] f, output logic [7:0] q);
    q = 8'h00;
    o_cs_n = 1'b0;
    for (int i = 0; i < 16; i++) begin
      o_sdi = (f[0] && i > 7) ? i[0] : f[i]; // Unused data keeps toggling
      repeat (8) @(negedge i_clk);
      o_sclk = 1'b1;
      if (i > 7) q[i-8] = i_sdo;
      repeat (8) @(negedge i_clk);
      o_sclk = 1'b0;
    end
    o_cs_n = 1'b1;
    repeat (12) @(negedge i_clk);
  endtask
endmodule // liu_host_model

// File: verification/liu_status_interrupt_regs_tb_top.sv
`timescale 1ns/100ps
module liu_status_interrupt_regs_tb_top;
  import liu_regs_pkg::*;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic clk = 0, rstn = 0, mp = 0, mon_on = 1, tp = 1, tn = 0, perr = 0;
  logic receive_signal_loss = 0, receive_lock_loss = 0, analog_signal_loss = 0, digital_signal_loss = 0, fl = 0, ja = 1;
  logic sclk, sdi, cs_n, sdo, sdoe, int_n, lp, lpoe, ln, lnoe, rxp, frst;
  logic [7:0] q;
  int failures = 0, checks_done = 0, nrst = 0;
  // Clock, monitor pulses, reset pulse count
  always #10 clk = ~clk;
  always @(negedge clk) mp <= mon_on & ~mp;
  always @(posedge clk) if (frst === 1'b1) nrst++;
  liu_status_interrupt_regs #(.BIT_DIV(1), .PART_ID(8'ha7), .REV_ID(8'h3c)) i_dut (
    .I_REF_CLK(clk), .I_RSTN(rstn), .I_SCLK(sclk), .I_SDI(sdi), .I_CS_N(cs_n),
    .O_SDO(sdo), .O_SDO_OE(sdoe), .O_INT_N(int_n), .I_MONITOR_IN_POSITIVE(mp),
    .I_MONITOR_IN_NEGATIVE(1'b0), .I_TX_POS_DATA(tp), .I_TX_NEG_DATA(tn),
    .O_LINE_TX_POSITIVE(lp), .O_LINE_TX_POSITIVE_OE(lpoe), .O_LINE_TX_NEGATIVE(ln),
    .O_LINE_TX_NEGATIVE_OE(lnoe), .O_RECEIVER_POWER(rxp), .I_RECEIVE_SIGNAL_LOSS(receive_signal_loss),
    .I_RECEIVE_LOCK_LOSS(receive_lock_loss), .I_ANALOG_SIGNAL_LOSS(analog_signal_loss), .I_DIGITAL_SIGNAL_LOSS(digital_signal_loss),
    .I_FIFO_LIMIT(fl), .I_JA_ENABLED(ja), .I_PATTERN_ERROR(perr), .O_FIFO_RESET(frst));
  liu_host_model i_host (.i_clk(clk), .i_sdo(sdo), .o_sclk(sclk), .o_sdi(sdi), .o_cs_n(cs_n));
  // ----------------------------------------
  // Shared checks and accesses
  // ----------------------------------------
  task chk(input string n, input logic [15:0] e, s);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task rd(input logic [5:0] a, input logic [7:0] e, input string n);
    i_host.xfer({8'h00, 1'b0, a, 1'b1}, q);
    chk(n, {8'h00, e}, {8'h00, q});
    chk("sdo oe released", 0, sdoe);
  endtask
  task wr(input logic [5:0] a, input logic [7:0] d);
    i_host.xfer({d, 1'b0, a, 1'b0}, q);
  endtask
  task stop_test;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset;
    rd(ADDR_POWER, 8'h00, "power");
    rd(ADDR_IRQ_EN, 8'h00, "enable");
    rd(ADDR_PART_ID, 8'ha7, "part");
    rd(ADDR_REV_ID, 8'h3c, "rev");
    rd(6'h10, 8'h00, "unmapped");
    chk("int_n", 1, int_n);
    $display("test reset done");
  endtask
  task t_power;
    wr(ADDR_POWER, 8'h11);
    chk("rx on", 1, rxp);
    chk("tx on", 4'b1110, {lpoe, lnoe, lp, ln});
    rd(ADDR_POWER, 8'h11, "power");
    wr(ADDR_POWER, 8'h10);
    chk("tx off", 3'b001, {lpoe, lnoe, rxp});
    wr(ADDR_POWER, 8'h01);
    chk("rx off", 0, rxp);
    $display("test power done");
  endtask
  task t_alarm;
    {digital_signal_loss, analog_signal_loss, receive_lock_loss, receive_signal_loss} = 4'hf;
    rd(ADDR_ALARM, 8'h36, "alarm");
    chk("int masked", 1, int_n);
    wr(ADDR_GIRQ_CTRL, 8'h01);
    wr(ADDR_IRQ_EN, 8'h04);
    chk("int lock", 0, int_n);
    rd(ADDR_GIRQ_STATE, 8'h01, "pending");
    rd(ADDR_IRQ_FLAGS, 8'h06, "flags");
    chk("int clear", 1, int_n);
    {digital_signal_loss, analog_signal_loss, receive_lock_loss, receive_signal_loss} = 4'h0;
    rd(ADDR_IRQ_FLAGS, 8'h06, "flags fall");
    rd(ADDR_IRQ_FLAGS, 8'h00, "flags read");
    $display("test alarm done");
  endtask
  task t_pattern;
    wr(ADDR_IRQ_EN, 8'h10);
    repeat (3) begin
      perr = 1;
      @(negedge clk) perr = 0;
      @(negedge clk);
    end
    chk("int pattern", 0, int_n);
    rd(ADDR_IRQ_FLAGS, 8'h10, "pattern flag");
    rd(ADDR_ERR_HIGH, 8'h00, "count high");
    rd(ADDR_HOLD, 8'h03, "count hold");
    rd(ADDR_ERR_LOW, 8'h00, "count cleared");
    $display("test pattern done");
  endtask
  task t_driver;
    wr(ADDR_IRQ_EN, 8'h01);
    mon_on = 0;
    repeat (140) @(negedge clk);
    rd(ADDR_ALARM, 8'h01, "driver alarm");
    chk("int driver", 0, int_n);
    mon_on = 1;
    repeat (8) @(negedge clk);
    rd(ADDR_IRQ_FLAGS, 8'h01, "driver flag");
    $display("test driver done");
  endtask
  task t_fifo;
    fl = 1;
    wr(ADDR_IRQ_EN, 8'h08);
    chk("int fifo", 0, int_n);
    ja = 0;
    repeat (3) @(negedge clk);
    chk("int ja off", 1, int_n);
    rd(ADDR_ALARM, 8'h08, "fifo alarm");
    chk("fifo reset", 1, nrst);
    rd(ADDR_ALARM, 8'h00, "fifo masked");
    $display("test fifo done");
  endtask
  task t_sat;
    wr(ADDR_IRQ_EN, 8'h20);
    perr = 1;
    rd(ADDR_ALARM, 8'h40, "pattern live");
    repeat (65000) @(negedge clk);
    chk("int not full", 1, int_n);
    repeat (400) @(negedge clk);
    perr = 0;
    chk("int full", 0, int_n);
    rd(ADDR_IRQ_FLAGS, 8'h38, "full flag");
    rd(ADDR_ERR_HIGH, 8'hff, "count sat");
    rd(ADDR_HOLD, 8'hff, "hold sat");
    $display("test saturation done");
  endtask
  // Watchdog and main sequence
  initial begin
    repeat (90000) @(posedge clk);
    failures++;
    stop_test;
  end
  initial begin
    repeat (8) @(negedge clk);
    rstn = 1;
    repeat (3) @(negedge clk);
    t_reset;
    t_power;
    t_alarm;
    t_pattern;
    t_driver;
    t_fifo;
    t_sat;
    stop_test;
  end
endmodule // liu_status_interrupt_regs_tb_top
